// ---- pkg/nand_host_pkg.sv ----
package nand_host_pkg;

    // Clock and pin timing
    localparam int CLK_MHZ = 50;
    localparam int WB_NS = 100;
    localparam int WB_CYC = (WB_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] WB_LAST = 4'(WB_CYC - 1);
    localparam logic [2:0] PH_LAST = 3'h4;

    // Page buffer
    localparam int PAGE_BYTES = 528;
    localparam int PTR_W = 10;
    localparam logic [9:0] PAGE_MAX = 10'h210;

    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ROW = 8'h04;
    localparam logic [7:0] OFS_COL = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_PTR = 8'h18;

    // Status register field positions
    localparam int STAT_BUSY = 8;
    localparam int STAT_ERR = 9;
    localparam int STAT_RB = 10;

    // Reset values
    localparam logic [17:0] ROW_RST = 18'h00000;
    localparam logic [7:0] COL_RST = 8'h00;
    localparam logic [9:0] COUNT_RST = 10'h000;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Device command bytes
    localparam logic [7:0] C_MAIN = 8'h00;
    localparam logic [7:0] C_HALF2 = 8'h01;
    localparam logic [7:0] C_SPARE = 8'h50;
    localparam logic [7:0] C_LOAD = 8'h80;
    localparam logic [7:0] C_PROG = 8'h10;
    localparam logic [7:0] C_DUMMY = 8'h11;
    localparam logic [7:0] C_ERASE = 8'h60;
    localparam logic [7:0] C_ERCONF = 8'hd0;
    localparam logic [7:0] C_STAT = 8'h70;
    localparam logic [7:0] C_MSTAT = 8'h71;
    localparam logic [7:0] C_RESET = 8'hff;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROG = 3'h1,
        OP_ERASE = 3'h2,
        OP_STATUS = 3'h3,
        OP_RESET = 3'h4
    } op_t;

    typedef enum logic [1:0] {
        AREA_A = 2'h0,
        AREA_B = 2'h1,
        AREA_C = 2'h2
    } area_t;

    // Control word as written at OFS_CTRL bits 6:0
    typedef struct packed {
        logic last;
        logic multi;
        area_t area;
        op_t op;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{last: 1'b0, multi: 1'b0, area: AREA_A, op: OP_READ};

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_PTR = 4'h1,
        S_CMD = 4'h3,
        S_ADDR = 4'h2,
        S_WDATA = 4'h6,
        S_CONF = 4'h7,
        S_WB = 4'h5,
        S_RDY = 4'h4,
        S_RDATA = 4'hc
    } state_t;

    // Outgoing flash pins
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic io_oe;
        logic [7:0] io_out;
    } pins_t;

    localparam pins_t PINS_RST = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                   read_strobe_n: 1'b1, io_oe: 1'b0, io_out: 8'h00};

endpackage

// ---- hw/page_buffer.sv ----
`timescale 1ns/1ns
module page_buffer (
    // Clock
    input wire logic clock,
    // Access
    input wire logic [nand_host_pkg::PTR_W-1:0] addr,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_ff
);
    logic [7:0] mem [nand_host_pkg::PAGE_BYTES];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_ff <= mem[addr];
    end
endmodule // page_buffer

// ---- hw/nand_host.sv ----
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - Pointer command sent before every load command
// - Half B pointer sent directly before load
// - Device buffers across chip enable gaps
// - Reads end within block by chip enable
// - Refuse second main-area or third spare-area partial program of one page; code counts only the last page programmed
// - Program needs load, address, data, confirm
// - Dummy confirm per plane, true confirm last
// - Refuse multi-plane program with half B
// - Each block addressed before one erase confirm
module nand_host (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash pins
    output nand_host_pkg::pins_t pins,
    input wire logic [7:0] io_in,
    input wire logic rb_n
);
    nand_host_pkg::state_t st_ff, nxt_st;
    nand_host_pkg::ctrl_t ctrl_ff, nxt_ctrl;
    nand_host_pkg::pins_t pins_ff, nxt_pins;
    logic [2:0] ph_ff, nxt_ph;
    logic [9:0] cnt_ff, nxt_cnt;
    logic [3:0] wait_ff, nxt_wait;
    logic [9:0] ptr_ff, nxt_ptr;
    logic [17:0] row_ff, nxt_row;
    logic [7:0] col_ff, nxt_col;
    logic [9:0] count_ff, nxt_count;
    logic [7:0] status_ff, nxt_status;
    logic err_ff, nxt_err;
    logic [17:0] last_row_ff, nxt_last_row;
    logic main_cnt_ff, nxt_main_cnt;
    logic [1:0] spare_cnt_ff, nxt_spare_cnt;
    logic [31:0] prdata_ff, nxt_prdata;
    logic acc_ff, nxt_acc;
    logic rb_s1_ff, rb_s2_ff;
    logic [7:0] io_s1_ff, io_s2_ff;
    logic [7:0] rdata;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic busy, cyc_end, wr_ok, rd_ok, mapped, refuse;
    logic [7:0] byte_out;
    nand_host_pkg::ctrl_t req;

    // Byte of a command or address cycle
    function automatic logic [7:0] cyc_byte(input nand_host_pkg::state_t s,
            input nand_host_pkg::ctrl_t c, input logic [9:0] n,
            input logic [17:0] r, input logic [7:0] col, input logic [7:0] d);
        logic [7:0] b;
        b = d;
        case (s)
            nand_host_pkg::S_PTR: begin
                b = (c.area == nand_host_pkg::AREA_B) ? nand_host_pkg::C_HALF2 :
                    (c.area == nand_host_pkg::AREA_C) ? nand_host_pkg::C_SPARE :
                    nand_host_pkg::C_MAIN;
            end
            nand_host_pkg::S_CMD: begin
                case (c.op)
                    nand_host_pkg::OP_PROG: b = nand_host_pkg::C_LOAD;
                    nand_host_pkg::OP_ERASE: b = nand_host_pkg::C_ERASE;
                    nand_host_pkg::OP_STATUS: b = c.multi ? nand_host_pkg::C_MSTAT
                                                          : nand_host_pkg::C_STAT;
                    default: b = nand_host_pkg::C_RESET;
                endcase
            end
            nand_host_pkg::S_ADDR: begin
                case (n[1:0])
                    2'h0: b = (c.area == nand_host_pkg::AREA_C) ? {4'h0, col[3:0]} : col;
                    2'h1: b = r[7:0];
                    2'h2: b = r[15:8];
                    default: b = {6'h00, r[17:16]};
                endcase
            end
            nand_host_pkg::S_CONF: begin
                b = (c.op == nand_host_pkg::OP_ERASE) ? nand_host_pkg::C_ERCONF :
                    c.last ? nand_host_pkg::C_PROG : nand_host_pkg::C_DUMMY;
            end
            default: b = d;
        endcase
        return b;
    endfunction

    page_buffer u_buf (
        .clock(clock),
        .addr(ptr_ff),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata_ff(rdata)
    );

    // APB decode; every access waits one cycle so read data come from a flop
    assign busy = (st_ff != nand_host_pkg::S_IDLE);
    assign mapped = (paddr == nand_host_pkg::OFS_CTRL) || (paddr == nand_host_pkg::OFS_ROW) ||
                    (paddr == nand_host_pkg::OFS_COL) || (paddr == nand_host_pkg::OFS_COUNT) ||
                    (paddr == nand_host_pkg::OFS_STAT) || (paddr == nand_host_pkg::OFS_DATA) ||
                    (paddr == nand_host_pkg::OFS_PTR);
    assign pready = psel & penable & acc_ff;
    assign pslverr = pready & (!mapped || (busy && (pwrite || paddr == nand_host_pkg::OFS_DATA)));
    assign wr_ok = pready & !pslverr & pwrite;
    assign rd_ok = pready & !pslverr & !pwrite;
    assign prdata = prdata_ff;
    assign pins = pins_ff;
    assign cyc_end = (ph_ff == nand_host_pkg::PH_LAST);
    assign byte_out = cyc_byte(st_ff, ctrl_ff, cnt_ff, row_ff, col_ff, rdata);
    assign req = nand_host_pkg::ctrl_t'(pwdata[6:0]);

    // Program and read limits, incl. partial program count of the last programmed page
    always_comb begin
        refuse = 1'b0;
        if (req.op == nand_host_pkg::OP_READ || req.op == nand_host_pkg::OP_PROG) begin
            refuse = (count_ff == 10'h000) || (count_ff > nand_host_pkg::PAGE_MAX);
        end
        if (req.op == nand_host_pkg::OP_PROG) begin
            if (req.multi && req.area == nand_host_pkg::AREA_B) begin
                refuse = 1'b1;
            end
            if (row_ff == last_row_ff) begin
                if (req.area == nand_host_pkg::AREA_C) begin
                    refuse = refuse | (spare_cnt_ff == 2'h2);
                end else begin
                    refuse = refuse | main_cnt_ff;
                end
            end
        end
    end

    always_comb begin
        nxt_acc = psel & penable & !acc_ff;
        nxt_prdata = prdata_ff;
        if (psel && penable && !acc_ff) begin
            case (paddr)
                nand_host_pkg::OFS_CTRL: nxt_prdata = {25'h0, ctrl_ff};
                nand_host_pkg::OFS_ROW: nxt_prdata = {14'h0, row_ff};
                nand_host_pkg::OFS_COL: nxt_prdata = {24'h0, col_ff};
                nand_host_pkg::OFS_COUNT: nxt_prdata = {22'h0, count_ff};
                nand_host_pkg::OFS_STAT: nxt_prdata = {21'h0, rb_s2_ff, err_ff, busy, status_ff};
                nand_host_pkg::OFS_DATA: nxt_prdata = {24'h0, rdata};
                nand_host_pkg::OFS_PTR: nxt_prdata = {22'h0, ptr_ff};
                default: nxt_prdata = 32'h0;
            endcase
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_ctrl = ctrl_ff;
        nxt_ph = cyc_end ? 3'h0 : 3'(ph_ff + 3'h1);
        nxt_cnt = cnt_ff;
        nxt_wait = 4'h0;
        nxt_ptr = ptr_ff;
        nxt_row = row_ff;
        nxt_col = col_ff;
        nxt_count = count_ff;
        nxt_status = status_ff;
        nxt_err = err_ff;
        nxt_last_row = last_row_ff;
        nxt_main_cnt = main_cnt_ff;
        nxt_spare_cnt = spare_cnt_ff;
        mem_we = 1'b0;
        mem_wdata = pwdata[7:0];
        if (wr_ok) begin
            case (paddr)
                nand_host_pkg::OFS_ROW: nxt_row = pwdata[17:0];
                nand_host_pkg::OFS_COL: nxt_col = pwdata[7:0];
                nand_host_pkg::OFS_COUNT: nxt_count = pwdata[9:0];
                nand_host_pkg::OFS_PTR: nxt_ptr = pwdata[9:0];
                nand_host_pkg::OFS_DATA: begin
                    mem_we = 1'b1;
                    nxt_ptr = 10'(ptr_ff + 10'h1);
                end
                default: begin
                    if (refuse) begin
                        nxt_err = 1'b1;
                    end else begin
                        nxt_ctrl = req;
                        nxt_err = 1'b0;
                        nxt_ptr = 10'h000;
                        nxt_ph = 3'h0;
                        nxt_st = (req.op == nand_host_pkg::OP_READ ||
                                  req.op == nand_host_pkg::OP_PROG) ? nand_host_pkg::S_PTR
                                                                   : nand_host_pkg::S_CMD;
                        if (req.op == nand_host_pkg::OP_PROG) begin
                            nxt_last_row = row_ff;
                            if (row_ff != last_row_ff) begin
                                nxt_main_cnt = 1'b0;
                                nxt_spare_cnt = 2'h0;
                            end
                            if (req.area == nand_host_pkg::AREA_C) begin
                                nxt_spare_cnt = (row_ff != last_row_ff) ? 2'h1
                                                : 2'(spare_cnt_ff + 2'h1);
                            end else begin
                                nxt_main_cnt = 1'b1;
                            end
                        end
                        if (req.op == nand_host_pkg::OP_ERASE && req.last) begin
                            nxt_main_cnt = 1'b0;
                            nxt_spare_cnt = 2'h0;
                        end
                    end
                end
            endcase
        end
        if (rd_ok && paddr == nand_host_pkg::OFS_DATA) begin
            nxt_ptr = 10'(ptr_ff + 10'h1);
        end
        case (st_ff)
            nand_host_pkg::S_IDLE: nxt_ph = 3'h0;
            nand_host_pkg::S_PTR: begin
                if (cyc_end) begin
                    nxt_cnt = 10'h000;
                    nxt_st = (ctrl_ff.op == nand_host_pkg::OP_READ) ? nand_host_pkg::S_ADDR
                                                                     : nand_host_pkg::S_CMD;
                end
            end
            nand_host_pkg::S_CMD: begin
                if (cyc_end) begin
                    nxt_cnt = (ctrl_ff.op == nand_host_pkg::OP_ERASE) ? 10'h001 : 10'h000;
                    nxt_st = (ctrl_ff.op == nand_host_pkg::OP_PROG ||
                              ctrl_ff.op == nand_host_pkg::OP_ERASE) ? nand_host_pkg::S_ADDR
                                                                     : nand_host_pkg::S_WB;
                end
            end
            nand_host_pkg::S_ADDR: begin
                if (cyc_end) begin
                    nxt_cnt = 10'(cnt_ff + 10'h1);
                    if (cnt_ff == 10'h003) begin
                        nxt_cnt = 10'h000;
                        case (ctrl_ff.op)
                            nand_host_pkg::OP_READ: nxt_st = nand_host_pkg::S_WB;
                            nand_host_pkg::OP_PROG: nxt_st = nand_host_pkg::S_WDATA;
                            default: nxt_st = ctrl_ff.last ? nand_host_pkg::S_CONF
                                                           : nand_host_pkg::S_IDLE;
                        endcase
                    end
                end
            end
            nand_host_pkg::S_WDATA: begin
                if (ph_ff == 3'h2) begin
                    nxt_ptr = 10'(ptr_ff + 10'h1);
                end
                if (cyc_end) begin
                    nxt_cnt = 10'(cnt_ff + 10'h1);
                    if (cnt_ff == 10'(count_ff - 10'h1)) begin
                        nxt_st = nand_host_pkg::S_CONF;
                    end
                end
            end
            nand_host_pkg::S_CONF: begin
                if (cyc_end) begin
                    nxt_st = nand_host_pkg::S_WB;
                end
            end
            nand_host_pkg::S_WB: begin
                nxt_ph = 3'h0;
                nxt_wait = 4'(wait_ff + 4'h1);
                if (wait_ff == nand_host_pkg::WB_LAST) begin
                    nxt_cnt = 10'h000;
                    nxt_st = (ctrl_ff.op == nand_host_pkg::OP_STATUS) ? nand_host_pkg::S_RDATA
                                                                       : nand_host_pkg::S_RDY;
                end
            end
            nand_host_pkg::S_RDY: begin
                nxt_ph = 3'h0;
                if (rb_s2_ff) begin
                    nxt_st = (ctrl_ff.op == nand_host_pkg::OP_READ) ? nand_host_pkg::S_RDATA
                                                                     : nand_host_pkg::S_IDLE;
                end
            end
            nand_host_pkg::S_RDATA: begin
                if (cyc_end) begin
                    nxt_cnt = 10'(cnt_ff + 10'h1);
                    if (ctrl_ff.op == nand_host_pkg::OP_STATUS) begin
                        nxt_status = io_s2_ff;
                        nxt_st = nand_host_pkg::S_IDLE;
                    end else begin
                        mem_we = 1'b1;
                        mem_wdata = io_s2_ff;
                        nxt_ptr = 10'(ptr_ff + 10'h1);
                        if (cnt_ff == 10'(count_ff - 10'h1)) begin
                            nxt_st = nand_host_pkg::S_IDLE;
                        end
                    end
                end
            end
            default: nxt_st = nand_host_pkg::S_IDLE;
        endcase
    end

    // Pins follow state one cycle late; data bus only changes at phase 0 for hold time
    always_comb begin
        nxt_pins = nand_host_pkg::PINS_RST;
        nxt_pins.io_out = pins_ff.io_out;
        nxt_pins.ce_n = !busy;
        case (st_ff)
            nand_host_pkg::S_PTR, nand_host_pkg::S_CMD, nand_host_pkg::S_ADDR,
            nand_host_pkg::S_WDATA, nand_host_pkg::S_CONF: begin
                nxt_pins.cle = (st_ff != nand_host_pkg::S_ADDR) && (st_ff != nand_host_pkg::S_WDATA);
                nxt_pins.ale = (st_ff == nand_host_pkg::S_ADDR);
                nxt_pins.io_oe = 1'b1;
                nxt_pins.we_n = (ph_ff > 3'h1);
                if (ph_ff == 3'h0) begin
                    nxt_pins.io_out = byte_out;
                end
            end
            nand_host_pkg::S_RDATA: nxt_pins.read_strobe_n = (ph_ff > 3'h1);
            default: nxt_pins.io_oe = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        rb_s1_ff <= rb_n;
        rb_s2_ff <= rb_s1_ff;
        io_s1_ff <= io_in;
        io_s2_ff <= io_s1_ff;
        if (!rst_b) begin
            st_ff <= nand_host_pkg::S_IDLE;
            ctrl_ff <= nand_host_pkg::CTRL_RST;
            pins_ff <= nand_host_pkg::PINS_RST;
            ph_ff <= 3'h0;
            cnt_ff <= 10'h000;
            wait_ff <= 4'h0;
            ptr_ff <= 10'h000;
            row_ff <= nand_host_pkg::ROW_RST;
            col_ff <= nand_host_pkg::COL_RST;
            count_ff <= nand_host_pkg::COUNT_RST;
            status_ff <= nand_host_pkg::STATUS_RST;
            err_ff <= 1'b0;
            last_row_ff <= nand_host_pkg::ROW_RST;
            main_cnt_ff <= 1'b0;
            spare_cnt_ff <= 2'h0;
            prdata_ff <= 32'h0;
            acc_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            ctrl_ff <= nxt_ctrl;
            pins_ff <= nxt_pins;
            ph_ff <= nxt_ph;
            cnt_ff <= nxt_cnt;
            wait_ff <= nxt_wait;
            ptr_ff <= nxt_ptr;
            row_ff <= nxt_row;
            col_ff <= nxt_col;
            count_ff <= nxt_count;
            status_ff <= nxt_status;
            err_ff <= nxt_err;
            last_row_ff <= nxt_last_row;
            main_cnt_ff <= nxt_main_cnt;
            spare_cnt_ff <= nxt_spare_cnt;
            prdata_ff <= nxt_prdata;
            acc_ff <= nxt_acc;
        end
    end
endmodule // nand_host

// ---- test/nand_host_props.sv ----
`timescale 1ns/1ns
module nand_host_props (
    // Clock, reset, APB
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Flash pins
    input nand_host_pkg::pins_t pins
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb wait wrong");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    we_pulse_a: assert property ($fell(pins.we_n) |=> !pins.we_n ##1 pins.we_n [*3])
        else $error("write strobe shape");
    rd_pulse_a: assert property ($fell(pins.read_strobe_n) |=> !pins.read_strobe_n ##1
        pins.read_strobe_n [*3]) else $error("read strobe shape");
    ce_frame_a: assert property (!(pins.we_n && pins.read_strobe_n) |-> !pins.ce_n)
        else $error("strobe outside select");
    latch_excl_a: assert property (!(pins.cle && pins.ale))
        else $error("both latches high");
    drive_dir_a: assert property (!pins.we_n |-> pins.io_oe && pins.read_strobe_n)
        else $error("bus not driven on write");
    rd_bus_a: assert property (!pins.read_strobe_n |-> !pins.io_oe)
        else $error("bus driven on read");
    io_hold_a: assert property ($fell(pins.we_n) |=> $stable(pins.io_out) [*2])
        else $error("bus moved in write cycle");
endmodule // nand_host_props
bind nand_host nand_host_props nand_host_props_inst (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .pins(pins));

// ---- test/nand_dev_model.sv ----
`timescale 1ns/1ns
module nand_dev_model #(
    parameter int BUSY_NS = 2000
) (
    // Host side
    input nand_host_pkg::pins_t pins,
    // Device side
    output logic [7:0] dev_q,
    output logic rb_n
);
    logic [7:0] mem [int];
    logic [7:0] cmds [$];
    logic [7:0] adr [$];
    logic [7:0] last_q = 8'h00;
    logic [1:0] area = 2'h0;
    logic stat_mode = 1'b0;
    int col = 0;
    int row = 0;
    initial rb_n = 1'b1;
    // Idle bus shows inverse of last byte so stale data never matches
    assign dev_q = (pins.ce_n || pins.read_strobe_n) ? ~last_q :
        stat_mode ? {1'b1, rb_n, 6'h00} : last_q;
    function automatic logic [7:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    // Blocking wait drops commands sent meanwhile
    task automatic busy();
        rb_n = 1'b0;
        #(BUSY_NS);
        rb_n = 1'b1;
        if (area == 2'h1) area = 2'h0;
    endtask
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.cle) begin
            cmds.push_back(pins.io_out);
            adr = {};
            stat_mode = pins.io_out inside {8'h70, 8'h71};
            case (pins.io_out)
                8'h00: area = 2'h0;
                8'h01: area = 2'h1;
                8'h50: area = 2'h2;
                8'hd0: begin
                    foreach (mem[k]) if ((k >> 15) == (row >> 5)) mem[k] = 8'hff;
                    busy();
                end
                8'h10, 8'h11, 8'hff: busy();
                default: ;
            endcase
        end else if (!pins.ce_n && pins.ale) begin
            adr.push_back(pins.io_out);
            if (adr.size() == 3 && cmds[$] == 8'h60) row = {adr[2], adr[1], adr[0]};
            if (adr.size() == 4) begin
                col = area == 2'h2 ? 512 + adr[0][3:0] : area * 256 + adr[0];
                row = {adr[3], adr[2], adr[1]};
                if (cmds[$] != 8'h80) busy();
            end
        end else if (!pins.ce_n) begin
            mem[row * 1024 + col] = pins.io_out & rd(row * 1024 + col);
            col++;
        end
    end
    always @(negedge pins.read_strobe_n) if (!pins.ce_n && !stat_mode) begin
        last_q = rd(row * 1024 + col);
        col++;
        if (col == 528) begin
            col = area == 2'h2 ? 512 : 0;
            row++;
            busy();
        end
    end
endmodule // nand_dev_model

// ---- test/tb_nand_host.sv ----
`timescale 1ns/1ns
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (x)); end end
module tb_nand_host;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;} row_t;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rb_n, e;
    nand_host_pkg::pins_t pins;
    logic [7:0] dev_q, io_in;
    logic [31:0] q;
    int n_mismatch = 0;
    int tests_run = 0;
    row_t rows [11] = '{'{8'h04, 0, 0, 0, 0}, '{8'h08, 0, 0, 0, 0}, '{8'h0c, 0, 0, 0, 0},
        '{8'h18, 0, 0, 0, 0}, '{8'h10, 0, 0, 32'h400, 0}, '{8'h04, 1, 32'hffffffff, 0, 0},
        '{8'h04, 0, 0, 32'h3ffff, 0}, '{8'h0c, 1, 32'h1234, 0, 0}, '{8'h0c, 0, 0, 32'h234, 0},
        '{8'h1c, 0, 0, 0, 1}, '{8'h20, 1, 32'h1, 0, 1}};
    always #10 clock = ~clock;
    assign io_in = pins.io_oe ? pins.io_out : dev_q;
    nand_host nand_host_inst (.clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .io_in(io_in), .rb_n(rb_n));
    nand_dev_model nand_dev_model_inst (.pins(pins), .dev_q(dev_q), .rb_n(rb_n));
    task automatic close_out();
        $display("Mismatches %0d in %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) n_mismatch++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle();
        int n;
        n = 0;
        q = 32'h100;
        while (q[8] !== 1'b0 && n < 400) begin
            apb(nand_host_pkg::OFS_STAT, 1'b0, 32'h0);
            n++;
        end
        if (n == 400) n_mismatch++;
    endtask
    task automatic op(input logic [6:0] c, input logic [17:0] r, input logic [7:0] cl,
            input logic [9:0] n);
        apb(nand_host_pkg::OFS_ROW, 1'b1, {14'h0, r});
        apb(nand_host_pkg::OFS_COL, 1'b1, {24'h0, cl});
        apb(nand_host_pkg::OFS_COUNT, 1'b1, {22'h0, n});
        apb(nand_host_pkg::OFS_CTRL, 1'b1, {25'h0, c});
        idle();
    endtask
    task automatic bytes(input logic [31:0] w, input int n, input logic chk);
        apb(nand_host_pkg::OFS_PTR, 1'b1, 32'h0);
        for (int i = 0; i < n; i++) begin
            apb(nand_host_pkg::OFS_DATA, !chk, {24'h0, w[8 * i +: 8]});
            if (chk) `CHK(q[7:0], w[8 * i +: 8])
        end
    endtask
    function automatic logic [23:0] tail();
        return {nand_dev_model_inst.cmds[$-2], nand_dev_model_inst.cmds[$-1],
            nand_dev_model_inst.cmds[$]};
    endfunction
    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            `CHK({e, q & {32{!rows[i].w}}}, {rows[i].e, rows[i].q})
        end
        bytes(32'hf00f3ca5, 4, 1'b0);
        op(7'h41, 18'h00021, 8'h10, 10'd4);
        `CHK({q[9], tail()}, 25'h0008010)
        op(7'h00, 18'h00021, 8'h10, 10'd4);
        bytes(32'hf00f3ca5, 4, 1'b1);
        op(7'h41, 18'h00021, 8'h00, 10'd1);
        `CHK(q[9], 1'b1)
        bytes(32'h5a, 1, 1'b0);
        op(7'h49, 18'h00040, 8'h05, 10'd1);
        `CHK(tail(), 24'h018010)
        op(7'h08, 18'h00040, 8'h05, 10'd1);
        bytes(32'h5a, 1, 1'b1);
        op(7'h69, 18'h00080, 8'h00, 10'd1);
        `CHK(q[9], 1'b1)
        op(7'h00, 18'h00080, 8'h00, 10'd0);
        `CHK(q[9], 1'b1)
        for (int i = 0; i < 3; i++) begin
            op(7'h51, 18'h00080, 8'h02, 10'd1);
            `CHK(q[9], i == 2)
        end
        op(7'h10, 18'h00080, 8'h12, 10'd1);
        bytes(32'h5a, 1, 1'b1);
        op(7'h21, 18'h00040, 8'h00, 10'd1);
        `CHK(nand_dev_model_inst.cmds[$], 8'h11)
        op(7'h03, 18'h0, 8'h00, 10'd1);
        `CHK({nand_dev_model_inst.cmds[$], q[7:0]}, 16'h70c0)
        op(7'h23, 18'h0, 8'h00, 10'd1);
        `CHK({nand_dev_model_inst.cmds[$], q[7:0]}, 16'h71c0)
        op(7'h02, 18'h00080, 8'h00, 10'd1);
        op(7'h42, 18'h00040, 8'h00, 10'd1);
        `CHK(tail(), 24'h6060d0)
        op(7'h08, 18'h00040, 8'h05, 10'd1);
        bytes(32'hff, 1, 1'b1);
        op(7'h49, 18'h00040, 8'h05, 10'd1);
        `CHK(q[9], 1'b0)
        apb(nand_host_pkg::OFS_CTRL, 1'b1, 32'h0);
        apb(nand_host_pkg::OFS_ROW, 1'b1, 32'h1);
        `CHK(e, 1'b1)
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        `CHK(pins.ce_n, 1'b1)
        apb(nand_host_pkg::OFS_STAT, 1'b0, 32'h0);
        `CHK(q[9:8], 2'h0)
        op(7'h04, 18'h0, 8'h00, 10'd1);
        `CHK(nand_dev_model_inst.cmds[$], 8'hff)
        close_out();
    end
endmodule // tb_nand_host
